// ### tb_three_wire_serial_channel.sv
// Purpose: Self-checking bench for the three-wire serial channel
// Assumes: 20 MHz mclk, peer model on the serial lines
// Notes: Clock pin follows ext_sck, idle high, when the channel does not drive it

`timescale 1ns/1ps

module tb_three_wire_serial_channel;
	localparam logic [15:0] AC = tws_pkg::ADDR_CLK_SEL;
	localparam logic [15:0] AM = tws_pkg::ADDR_MODE;
	localparam logic [15:0] AD = tws_pkg::ADDR_DATA;
	localparam logic [15:0] AS = tws_pkg::ADDR_STAT;
	logic mclk, rst_n, osc, wr, rd, load, si, done, ext_sck;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, ptx, prx, d;
	tws_pkg::tws_pins_t pins;
	wire sck = pins.sck_oe ? pins.sck_out : ext_sck;
	int miscompares, checked, falls, t1, t2;

	tws_channel u_tws_channel (
		.mclk(mclk),
		.rst_n(rst_n),
		.oscillation_mode_bit(osc),
		.reg_addr(addr),
		.reg_wdata(wdata),
		.reg_wr(wr),
		.reg_rd(rd),
		.reg_rdata(rdata),
		.serial_clock_pin_in(sck),
		.serial_in_pin(si),
		.pins(pins),
		.transfer_complete(done)
	);

	tws_peer u_tws_peer (
		.sck(sck),
		.so(pins.so_out),
		.load(load),
		.tx(ptx),
		.si(si),
		.rx(prx)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic complete_run;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wrr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wrr

	task automatic rdr(input logic [15:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rdr

	task automatic watch(input int n, input bit stop);
		logic p;
		p = sck;
		falls = 0;
		t1 = 0;
		t2 = 0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			#1;
			if (p && !sck)
			begin
				falls++;
				if (falls == 1) t1 = i;
				if (falls == 2) t2 = i;
			end
			p = sck;
			if (stop && done === 1'b1)
				return;
		end
		if (stop)
		begin
			miscompares++;
			complete_run();
		end
	endtask : watch

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdr(AC, d);
		chk(d, 8'h88);
		@(posedge mclk);
		#1;
		chk(rdata, 8'h00);
		rdr(AM, d);
		chk(d, 8'h00);
		rdr(16'h0000, d);
		chk(d, 8'h00);
		wrr(AM, 8'hff);
		rdr(AM, d);
		chk(d, 8'hc3);
		wrr(AM, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_stop;
		wrr(AD, 8'h5a);
		watch(40, 0);
		chk(falls[15:0], 16'h0000);
		rdr(AD, d);
		chk(d, 8'h5a);
		chk({7'h00, done}, 8'h00);
		chk({7'h00, pins.so_oe}, 8'h00);
		$display("test stop done");
	endtask : t_stop

	task automatic xfer(input logic [7:0] m, input logic o, input logic [3:0] c, input logic [7:0] w,
		input logic [7:0] pt, input logic [7:0] erx, input logic [7:0] erd);
		int h;
		h = 1 << (int'(c) - 6 + (o ? 0 : 1));
		@(posedge mclk);
		osc <= o;
		ptx <= pt;
		load <= 1'b1;
		wrr(AC, {c, 4'h8});
		load <= 1'b0;
		wrr(AM, m);
		wrr(AD, w);
		@(posedge mclk);
		#1;
		chk({7'h00, done}, 8'h00);
		chk({7'h00, pins.so_oe}, 8'h01);
		watch(20000, 1);
		chk(falls[15:0], 16'h0008);
		chk(16'(t2 - t1), 16'(2 * h));
		chk(prx, erx);
		rdr(AD, d);
		chk(d, erd);
		chk({7'h00, sck}, 8'h01);
		rdr(AS, d);
		chk(d, 8'h01);
		$display("test transfer done");
	endtask : xfer

	task automatic t_abort;
		wrr(AC, 8'h98);
		wrr(AM, 8'h83);
		wrr(AD, 8'h33);
		watch(30, 0);
		chk(falls[15:0], 16'h0001);
		wrr(AM, 8'h00);
		watch(300, 0);
		chk(falls[15:0], 16'h0000);
		rdr(AS, d);
		chk(d, 8'h00);
		$display("test abort done");
	endtask : t_abort

	task automatic t_ext;
		@(posedge mclk);
		ptx <= 8'h69;
		load <= 1'b1;
		wrr(AM, 8'h80);
		load <= 1'b0;
		wrr(AD, 8'h4b);
		chk({7'h00, pins.sck_oe}, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			repeat (8) @(posedge mclk);
			ext_sck <= 1'b0;
			repeat (8) @(posedge mclk);
			ext_sck <= 1'b1;
		end
		repeat (8) @(posedge mclk);
		#1;
		chk({7'h00, done}, 8'h01);
		chk(prx, 8'h4b);
		rdr(AD, d);
		chk(d, 8'h69);
		$display("test external clock done");
	endtask : t_ext

	task automatic t_nostart(input logic [7:0] m, input logic o, input logic [3:0] c);
		@(posedge mclk);
		osc <= o;
		wrr(AC, {c, 4'h8});
		wrr(AM, m);
		wrr(AD, 8'h96);
		watch(200, 0);
		chk(falls[15:0], 16'h0000);
		chk({7'h00, done}, 8'h00);
		wrr(AM, 8'h00);
		$display("test no start done");
	endtask : t_nostart

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_n, osc, wr, rd, load} = 5'h00;
		addr = 16'h0000;
		wdata = 8'h00;
		ptx = 8'h00;
		ext_sck = 1'b1;
		miscompares = 0;
		checked = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_stop();
		xfer(8'h83, 1'b1, 4'h7, 8'ha5, 8'h3c, 8'ha5, 8'h3c);
		xfer(8'hc3, 1'b1, 4'h9, 8'h0e, 8'hc1, 8'h70, 8'h83);
		xfer(8'h83, 1'b0, 4'h6, 8'hff, 8'h00, 8'hff, 8'h00);
		xfer(8'h83, 1'b0, 4'hd, 8'h00, 8'hff, 8'h00, 8'hff);
		t_ext();
		t_abort();
		t_nostart(8'h82, 1'b1, 4'h9);
		t_nostart(8'h83, 1'b1, 4'h6);
		t_nostart(8'h83, 1'b0, 4'he);
		complete_run();
	end
endmodule : tb_three_wire_serial_channel

// ### tws_channel.sv
// Purpose: Three-wire clocked serial channel with register port
// Assumes: mclk is the oscillator clock; serial pins are asynchronous
// Notes: Prohibited rate codes stall the transfer; clock source 10 does not start one

`timescale 1ns/1ps

module tws_channel (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic oscillation_mode_bit,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic serial_clock_pin_in,
	input wire logic serial_in_pin,
	output tws_pkg::tws_pins_t pins,
	output logic transfer_complete
);

	tws_pkg::tws_chan_state_t st;
	tws_pkg::tws_chan_state_t next_st;
	logic en;
	logic lsb_first;
	logic src_ext;
	logic src_int;
	logic busy;
	logic code_ok;
	logic [3:0] code;
	logic [3:0] half_exp;
	logic tick;
	logic ext_rise;
	logic ext_fall;
	logic wr_data;
	logic [3:0] cnt_inc;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] tws_rev(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction : tws_rev

	// ----------------------------------------
	// Rate select
	// ----------------------------------------
	always_comb
	begin
		code = st.clk_sel[tws_pkg::CODE_MSB:tws_pkg::CODE_LSB];
		// Base clock halved when the oscillation mode bit is 0
		half_exp = 4'(code - tws_pkg::HALF_BIAS + {3'b000, ~oscillation_mode_bit});
		// Only listed codes give a clock
		if (oscillation_mode_bit)
		begin
			code_ok = (code >= tws_pkg::CODE_MIN_FAST) && (code <= tws_pkg::CODE_MAX);
		end
		else
		begin
			code_ok = (code >= tws_pkg::CODE_MIN_SLOW) && (code <= tws_pkg::CODE_MAX);
		end
	end

	tws_clk_div u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(st.phase == tws_pkg::PH_HIGH || st.phase == tws_pkg::PH_LOW),
		.valid(code_ok),
		.half_exp(half_exp),
		.tick(tick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		en = st.mode[tws_pkg::MODE_EN_BIT];
		lsb_first = st.mode[tws_pkg::MODE_DIR_BIT];
		src_ext = !st.mode[tws_pkg::MODE_SRC_HI_BIT];
		src_int = st.mode[tws_pkg::MODE_SRC_HI_BIT] && st.mode[tws_pkg::MODE_SRC_LO_BIT];
		busy = st.phase != tws_pkg::PH_IDLE || st.sample_due;
		ext_rise = st.sck_s2 && !st.sck_s3;
		ext_fall = !st.sck_s2 && st.sck_s3;
		wr_data = reg_wr && reg_addr == tws_pkg::ADDR_DATA;
		cnt_inc = 4'(st.bit_cnt + 4'h1);
		next_st = st;

		// Pin synchronisers
		next_st.si_s1 = serial_in_pin;
		next_st.si_s2 = st.si_s1;
		next_st.si_s3 = st.si_s2;
		next_st.sck_s1 = serial_clock_pin_in;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_s3 = st.sck_s2;

		// Register writes
		if (reg_wr && reg_addr == tws_pkg::ADDR_CLK_SEL)
		begin
			next_st.clk_sel = reg_wdata;
		end
		if (reg_wr && reg_addr == tws_pkg::ADDR_MODE)
		begin
			next_st.mode = reg_wdata & tws_pkg::MODE_WRITE_MASK;
		end
		if (wr_data && !busy)
		begin
			// Plain storage in stop mode, order set on write
			next_st.shreg = lsb_first ? tws_rev(reg_wdata) : reg_wdata;
			if (en && (src_ext || src_int))
			begin
				// Start only with the channel enabled
				next_st.phase = src_ext ? tws_pkg::PH_EXT : tws_pkg::PH_HIGH;
				next_st.bit_cnt = 4'h0;
				next_st.done = 1'b0;
			end
		end

		// Capture one cycle after the rise, past the synchroniser
		if (st.sample_due)
		begin
			next_st.shreg = {st.shreg[6:0], st.si_s2};
			next_st.sample_due = 1'b0;
			if (st.bit_cnt == tws_pkg::WORD_BITS)
			begin
				next_st.done = 1'b1;
			end
		end

		// Shift engine
		case (st.phase)
			tws_pkg::PH_IDLE:
			begin
				next_st.pins.sck_out = 1'b1;
			end
			tws_pkg::PH_HIGH:
			begin
				if (tick)
				begin
					next_st.pins.sck_out = 1'b0;
					next_st.pins.so_out = st.shreg[7];
					next_st.phase = tws_pkg::PH_LOW;
				end
			end
			tws_pkg::PH_LOW:
			begin
				if (tick)
				begin
					// Rise now, capture queued for next cycle
					next_st.pins.sck_out = 1'b1;
					next_st.sample_due = 1'b1;
					next_st.bit_cnt = cnt_inc;
					next_st.phase = (cnt_inc == tws_pkg::WORD_BITS) ? tws_pkg::PH_IDLE : tws_pkg::PH_HIGH;
				end
			end
			tws_pkg::PH_EXT:
			begin
				if (ext_fall)
				begin
					next_st.pins.so_out = st.shreg[7];
				end
				if (ext_rise)
				begin
					// Value seen while the clock was still low
					next_st.shreg = {st.shreg[6:0], st.si_s3};
					next_st.bit_cnt = cnt_inc;
					if (cnt_inc == tws_pkg::WORD_BITS)
					begin
						next_st.phase = tws_pkg::PH_IDLE;
						next_st.done = 1'b1;
					end
				end
			end
			default:
			begin
				next_st.phase = tws_pkg::PH_IDLE;
			end
		endcase

		// Stop mode halts and clears the counter
		if (!en)
		begin
			next_st.phase = tws_pkg::PH_IDLE;
			next_st.bit_cnt = 4'h0;
			next_st.pins.sck_out = 1'b1;
		end
		// Pin drive
		next_st.pins.sck_oe = next_st.mode[tws_pkg::MODE_EN_BIT] && next_st.mode[tws_pkg::MODE_SRC_HI_BIT]
			&& next_st.mode[tws_pkg::MODE_SRC_LO_BIT];
		next_st.pins.so_oe = next_st.mode[tws_pkg::MODE_EN_BIT];

		// Register reads
		next_st.rdata = tws_pkg::ZERO_BYTE;
		if (reg_rd)
		begin
			case (reg_addr)
				tws_pkg::ADDR_CLK_SEL: next_st.rdata = st.clk_sel;
				tws_pkg::ADDR_MODE: next_st.rdata = st.mode;
				tws_pkg::ADDR_DATA: next_st.rdata = lsb_first ? tws_rev(st.shreg) : st.shreg;
				tws_pkg::ADDR_STAT:
				begin
					next_st.rdata[tws_pkg::STAT_DONE_BIT] = st.done;
					next_st.rdata[tws_pkg::STAT_BUSY_BIT] = busy;
				end
				default: next_st.rdata = tws_pkg::ZERO_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		st <= next_st;
		if (!rst_n)
		begin
			// Shift data left untouched by reset
			st.clk_sel <= tws_pkg::CLK_SEL_RESET;
			st.mode <= tws_pkg::MODE_RESET;
			st.phase <= tws_pkg::PH_IDLE;
			st.bit_cnt <= 4'h0;
			st.done <= 1'b0;
			st.pins <= '{sck_out: 1'b1, sck_oe: 1'b0, so_out: 1'b0, so_oe: 1'b0};
			st.rdata <= tws_pkg::ZERO_BYTE;
			st.si_s1 <= 1'b0;
			st.si_s2 <= 1'b0;
			st.si_s3 <= 1'b0;
			st.sample_due <= 1'b0;
			st.sck_s1 <= 1'b1;
			st.sck_s2 <= 1'b1;
			st.sck_s3 <= 1'b1;
		end
	end

	assign reg_rdata = st.rdata;
	assign pins = st.pins;
	assign transfer_complete = st.done;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_last_rise;
		st.phase == tws_pkg::PH_LOW && tick && st.bit_cnt == tws_pkg::LAST_BIT && en;
	endsequence

	sequence s_sampling;
		st.sample_due && st.phase == tws_pkg::PH_IDLE && st.bit_cnt == tws_pkg::WORD_BITS;
	endsequence

	sequence s_finished;
		st.done && st.phase == tws_pkg::PH_IDLE && !st.sample_due;
	endsequence

	sequence s_ext_last;
		st.phase == tws_pkg::PH_EXT && ext_rise && st.bit_cnt == tws_pkg::LAST_BIT && en;
	endsequence

	chk_stop_no_activity: assert property (!en |=> st.phase == tws_pkg::PH_IDLE && st.bit_cnt == 4'h0)
		else $error("Channel active while stopped");

	chk_start_needs_en: assert property (wr_data && !en && !busy |=> st.phase == tws_pkg::PH_IDLE)
		else $error("Transfer started with channel disabled");

	chk_start_when_en: assert property (wr_data && en && !busy && src_int |=> st.phase == tws_pkg::PH_HIGH)
		else $error("Enabled data write did not start transfer");

	chk_sck_idle_high: assert property (st.phase == tws_pkg::PH_IDLE |-> st.pins.sck_out)
		else $error("Serial clock not high between transfers");

	chk_count_bound: assert property (st.bit_cnt <= tws_pkg::WORD_BITS)
		else $error("Bit counter passed eight");

	chk_done_after_eight: assert property (s_last_rise |=> s_sampling ##1 s_finished)
		else $error("Complete flag not set after eighth clock");

	chk_ext_done: assert property (s_ext_last |=> s_finished)
		else $error("Complete flag not set after eighth external clock");

	chk_ext_sample: assert property (st.phase == tws_pkg::PH_EXT && ext_rise && en |=> st.shreg[0] == $past(st.si_s3))
		else $error("Serial in not sampled on external rising edge");

	chk_so_on_fall: assert property ($fell(st.pins.sck_out) |-> st.pins.so_out == $past(st.shreg[7]))
		else $error("Serial out not driven on falling edge");

	chk_sample_on_rise: assert property (st.phase == tws_pkg::PH_LOW && tick && en
		|=> st.sample_due ##1 st.shreg[0] == $past(st.si_s2))
		else $error("Serial in not sampled on rising edge");

	chk_clk_sel_reset: assert property (@(posedge mclk) disable iff (1'b0)
		!rst_n |=> st.clk_sel == tws_pkg::CLK_SEL_RESET && st.mode == tws_pkg::MODE_RESET)
		else $error("Clock select or mode reset value wrong");

	chk_read_data: assert property (reg_rd && reg_addr == tws_pkg::ADDR_DATA && !lsb_first
		|=> reg_rdata == $past(st.shreg))
		else $error("Shift data read mismatch");

endmodule : tws_channel

// ### tws_clk_div.sv
// Purpose: Half-period tick divider for the internal serial clock
// Assumes: half period is 2**half_exp mclk cycles, half_exp 1..8
// Notes: Counter restarts whenever run is low

`timescale 1ns/1ps

module tws_clk_div (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic valid,
	input wire logic [3:0] half_exp,
	output logic tick
);

	tws_pkg::tws_div_state_t st;
	tws_pkg::tws_div_state_t next_st;
	logic [8:0] span;
	logic [7:0] mask;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_comb
	begin
		span = 9'h001 << half_exp;
		mask = 8'(span - 9'h001);
		tick = run && valid && ((st.cnt & mask) == mask);
		next_st = st;
		next_st.cnt = run ? 8'(st.cnt + 8'h01) : 8'h00;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st.cnt <= 8'h00;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule : tws_clk_div

// ### tws_peer.sv
// Purpose: Far-side peripheral model on the three serial lines
// Assumes: Clock is the sck line, from the channel or ext_sck, and idles high
// Notes: Data line is inverted on load and at once on the eighth rising edge

`timescale 1ns/1ps

module tws_peer (
	input wire logic sck,
	input wire logic so,
	input wire logic load,
	input wire logic [7:0] tx,
	output logic si,
	output logic [7:0] rx
);
	logic [3:0] n;

	initial
	begin
		si = 1'b0;
		rx = 8'h00;
		n = 4'h0;
	end

	// New frame: line not yet valid
	always @(posedge load)
	begin
		n = 4'h0;
		si = ~si;
	end

	// Drive on falling edge, MSB first
	always @(negedge sck)
	begin
		si = tx[3'h7 - n[2:0]];
		n = n + 4'h1;
	end

	// Sample on rising edge
	always @(posedge sck)
	begin
		rx = {rx[6:0], so};
		if (n == 4'h8)
			si = ~si;
	end
endmodule : tws_peer

// ### tws_pkg.sv
// Purpose: Constants and types for the three-wire serial channel
// Assumes: mclk is the main oscillator clock (20 MHz)
// Notes: Register offsets are byte addresses on the plain register port
// Operation
// - Two modes only: operation stop and three-wire serial transfer.
// - In stop mode no serial clock, shifting or counting happens.
// - Each transfer moves one 8-bit word over clock, out and in lines.
// - Shift out and capture in happen in the same transfer.
// - Software picks MSB-first or LSB-first word order.
// - Shift data register is 8 bits, shifting with the serial clock.
// - Data write starts a transfer only when mode bit 7 is set.
// - Written data goes out on serial out; serial in bits are captured.
// - Shift data register has no defined reset value.
// - A counter counts serial clock edges to find the eighth bit.
// - Clock select register resets to 88H.
// - Clock select upper nibble picks internal rate; other codes prohibited.
// - Base clock is oscillator/2 with mode bit 0, oscillator with 1.
// - Mode register resets 00H; bit7 enable, bit6 order, bit5 zero.
// - Mode clock bits: 0x external, 11 internal driven, 10 prohibited.
// - When stopped, shift data register is a plain read/write register.

package tws_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_CLK_SEL = 16'hff44;
	localparam logic [15:0] ADDR_MODE = 16'hff6c;
	localparam logic [15:0] ADDR_DATA = 16'hff6d;
	localparam logic [15:0] ADDR_STAT = 16'hff6e;

	localparam logic [7:0] CLK_SEL_RESET = 8'h88;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] MODE_WRITE_MASK = 8'hc3;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_DIR_BIT = 6;
	localparam int MODE_SRC_HI_BIT = 1;
	localparam int MODE_SRC_LO_BIT = 0;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;

	// ----------------------------------------
	// Rate codes and counts
	// ----------------------------------------
	localparam logic [3:0] CODE_MIN_FAST = 4'h7;
	localparam logic [3:0] CODE_MIN_SLOW = 4'h6;
	localparam logic [3:0] CODE_MAX = 4'hd;
	localparam logic [3:0] HALF_BIAS = 4'h6;
	localparam logic [3:0] WORD_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW, PH_EXT} tws_phase_t;

	typedef struct packed {
		logic sck_out;
		logic sck_oe;
		logic so_out;
		logic so_oe;
	} tws_pins_t;

	typedef struct packed {
		logic [7:0] clk_sel;
		logic [7:0] mode;
		logic [7:0] shreg;
		tws_phase_t phase;
		logic [3:0] bit_cnt;
		logic done;
		tws_pins_t pins;
		logic [7:0] rdata;
		logic si_s1;
		logic si_s2;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic si_s3;
		logic sample_due;
	} tws_chan_state_t;

	typedef struct packed {
		logic [7:0] cnt;
	} tws_div_state_t;

endpackage : tws_pkg
